// [hdl/text_font_and_memory_fill_ctrl.v]
// host port, font selection registers, text code decoder and memory fill control
`timescale 1ns/10ps
`default_nettype none
`include "font_fill_regs.vh"

module text_font_and_memory_fill_ctrl (
    // clock and reset
    input  wire        CLOCK,
    input  wire        RST_N,
    // parallel host port
    input  wire        CS,
    input  wire        RS,
    input  wire        WR_N,
    input  wire        RD_N,
    input  wire [7:0]  DATA_IN,
    output wire [7:0]  DATA_OUT,
    output wire        DATA_OE,
    // active window from the window-boundary registers
    input  wire [7:0]  WINDOW_LEFT_BOUND,
    input  wire [7:0]  WINDOW_TOP_BOUND,
    input  wire [7:0]  WINDOW_RIGHT_BOUND,
    input  wire [7:0]  WINDOW_BOTTOM_BOUND,
    // text byte stream from the memory write path
    input  wire        TEXT_MODE,
    input  wire [7:0]  TEXT_BYTE,
    input  wire        TEXT_STROBE,
    // decoded character for the glyph renderer
    output wire [15:0] GLYPH_CODE,
    output wire        GLYPH_VALID,
    output wire        GLYPH_FULL_SIZE,
    output wire        FONT_ISO_SET,
    output wire [1:0]  FONT_BLOCK,
    output wire [2:0]  FONT_WIDTH_MUL,
    output wire [2:0]  FONT_HEIGHT_MUL,
    // display memory fill port
    output wire [7:0]  DISPLAY_MEMORY_COL,
    output wire [7:0]  DISPLAY_MEMORY_ROW,
    output wire [7:0]  DISPLAY_MEMORY_DATA,
    output wire        DISPLAY_MEMORY_WE
);

    // one-hot states of the text decoder
    localparam [1:0] DEC_FIRST  = 2'b01;
    localparam [1:0] DEC_SECOND = 2'b10;

    // synchronised host pins
    wire [3:0] ctl_s;
    wire [7:0] data_s;
    wire       cs_s;
    wire       rs_s;
    wire       wr_n_s;
    wire       rd_n_s;

    // host port state
    reg        wr_n_prev_ff;
    reg [7:0]  reg_addr_ff;
    reg [7:0]  rd_data_ff;
    reg        rd_oe_ff;
    reg [7:0]  nxt_rd_data;

    // register fields
    reg [7:0]  fill_pattern_ff;
    reg        iso_set_ff;
    reg        single_byte_ff;
    reg [1:0]  block_ff;
    reg [1:0]  hscale_ff;
    reg [1:0]  vscale_ff;
    reg [2:0]  width_mul_ff;
    reg [2:0]  height_mul_ff;

    // register decode and scale lookup
    reg        hit_pattern;
    reg        hit_control;
    reg        hit_scale;
    reg [2:0]  nxt_width_mul;
    reg [2:0]  nxt_height_mul;

    // text decoder state
    reg [1:0]  dec_state_ff;
    reg [7:0]  lead_byte_ff;
    reg [15:0] glyph_code_ff;
    reg        glyph_valid_ff;
    reg        glyph_full_ff;

    // fill engine hookup
    wire       fill_busy;
    wire       wr_take;
    wire       data_wr;
    wire       fill_start;

    // control pins idle high except chip select and register select
    pin_sync #(
        .WIDTH (4),
        .INIT  (4'b0011)
    ) u_ctl_sync (
        .clock    (CLOCK),
        .rst_n    (RST_N),
        .async_in ({CS, RS, WR_N, RD_N}),
        .sync_out (ctl_s)
    );

    // data bus shares the control latency so it pairs with the strobe edge
    pin_sync #(
        .WIDTH (8),
        .INIT  (8'h00)
    ) u_data_sync (
        .clock    (CLOCK),
        .rst_n    (RST_N),
        .async_in (DATA_IN),
        .sync_out (data_s)
    );

    assign cs_s   = ctl_s[3];
    assign rs_s   = ctl_s[2];
    assign wr_n_s = ctl_s[1];
    assign rd_n_s = ctl_s[0];

    // a write is taken on the rising write strobe while selected
    assign wr_take    = cs_s & wr_n_s & ~wr_n_prev_ff;
    assign data_wr    = wr_take & ~rs_s;
    // start only on a written one while idle; zero or restart is ignored
    // a start written while busy is dropped, not queued
    assign fill_start = data_wr & hit_control
                        & data_s[`FC_FILL_BIT] & ~fill_busy;

    // register hit decode shared by the write and read paths
    // unmapped offsets hit nothing, so writes there are dropped
    always @* begin
        hit_pattern = 1'b0;
        hit_control = 1'b0;
        hit_scale   = 1'b0;
        if (reg_addr_ff == `OFS_FILL_PATTERN) begin
            hit_pattern = 1'b1;
        end else if (reg_addr_ff == `OFS_FONT_CONTROL) begin
            hit_control = 1'b1;
        end else if (reg_addr_ff == `OFS_FONT_SCALE) begin
            hit_scale = 1'b1;
        end
    end

    // field value n renders at n+1 times the normal size
    // spelled out as a table so each code is visible
    always @* begin
        case (data_s[`FS_HSCALE_HI:`FS_HSCALE_LO])
            2'b00:   nxt_width_mul = 3'h1;
            2'b01:   nxt_width_mul = 3'h2;
            2'b10:   nxt_width_mul = 3'h3;
            default: nxt_width_mul = 3'h4;
        endcase
        case (data_s[`FS_VSCALE_HI:`FS_VSCALE_LO])
            2'b00:   nxt_height_mul = 3'h1;
            2'b01:   nxt_height_mul = 3'h2;
            2'b10:   nxt_height_mul = 3'h3;
            default: nxt_height_mul = 3'h4;
        endcase
    end

    // command phase picks the register; the strobe history finds the rising edge
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wr_n_prev_ff <= 1'b1;
            reg_addr_ff  <= 8'h00;
        end else begin
            wr_n_prev_ff <= wr_n_s;
            if (wr_take && rs_s) begin
                reg_addr_ff <= data_s;
            end
        end
    end

    // pattern byte for the fill
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            fill_pattern_ff <= `RST_FILL_PATTERN;
        end else if (data_wr && hit_pattern) begin
            fill_pattern_ff <= data_s;
        end
    end

    // font control fields; the fill bit itself lives in the engine
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            iso_set_ff     <= 1'b0;
            single_byte_ff <= 1'b0;
            block_ff       <= 2'b00;
        end else if (data_wr && hit_control) begin
            iso_set_ff     <= data_s[`FC_ISO_BIT];
            single_byte_ff <= data_s[`FC_SINGLE_BIT];
            block_ff       <= data_s[`FC_BLOCK_HI:`FC_BLOCK_LO];
        end
    end

    // scale fields read back raw; multipliers are looked up at write time
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            hscale_ff     <= 2'b00;
            vscale_ff     <= 2'b00;
            width_mul_ff  <= 3'h1;
            height_mul_ff <= 3'h1;
        end else if (data_wr && hit_scale) begin
            hscale_ff     <= data_s[`FS_HSCALE_HI:`FS_HSCALE_LO];
            vscale_ff     <= data_s[`FS_VSCALE_HI:`FS_VSCALE_LO];
            width_mul_ff  <= nxt_width_mul;
            height_mul_ff <= nxt_height_mul;
        end
    end

    // read mux; reserved bits and unmapped offsets read zero
    // a command-phase read returns the status byte
    always @* begin
        nxt_rd_data = 8'h00;
        if (rs_s) begin
            nxt_rd_data[`STAT_BUSY_BIT] = fill_busy;
        end else if (hit_pattern) begin
            nxt_rd_data = fill_pattern_ff;
        end else if (hit_control) begin
            nxt_rd_data[`FC_ISO_BIT]                 = iso_set_ff;
            nxt_rd_data[`FC_FILL_BIT]                = fill_busy;
            nxt_rd_data[`FC_SINGLE_BIT]              = single_byte_ff;
            nxt_rd_data[`FC_BLOCK_HI:`FC_BLOCK_LO]   = block_ff;
        end else if (hit_scale) begin
            nxt_rd_data[`FS_HSCALE_HI:`FS_HSCALE_LO] = hscale_ff;
            nxt_rd_data[`FS_VSCALE_HI:`FS_VSCALE_LO] = vscale_ff;
        end
    end

    // bus driven only while selected and read strobe low
    // enable trails the pins by the synchroniser and one stage
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rd_data_ff <= 8'h00;
            rd_oe_ff   <= 1'b0;
        end else begin
            rd_data_ff <= nxt_rd_data;
            rd_oe_ff   <= cs_s & ~rd_n_s;
        end
    end

    // text decoder: single-byte always, or mixed half/full codes in text mode
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            dec_state_ff   <= DEC_FIRST;
            lead_byte_ff   <= 8'h00;
            glyph_code_ff  <= 16'h0000;
            glyph_valid_ff <= 1'b0;
            glyph_full_ff  <= 1'b0;
        end else begin
            glyph_valid_ff <= 1'b0;
            case (dec_state_ff)
                // first byte: a half code now, or hold a lead byte
                DEC_FIRST: begin
                    if (TEXT_STROBE) begin
                        if (single_byte_ff || !TEXT_MODE) begin
                            glyph_code_ff  <= {8'h00, TEXT_BYTE};
                            glyph_full_ff  <= 1'b0;
                            glyph_valid_ff <= 1'b1;
                        end else if (TEXT_BYTE < `HALF_SIZE_LIMIT) begin
                            glyph_code_ff  <= {8'h00, TEXT_BYTE};
                            glyph_full_ff  <= 1'b0;
                            glyph_valid_ff <= 1'b1;
                        end else begin
                            lead_byte_ff <= TEXT_BYTE;
                            dec_state_ff <= DEC_SECOND;
                        end
                    end
                end
                DEC_SECOND: begin
                    // leaving text mode drops a half-received code
                    if (!TEXT_MODE) begin
                        dec_state_ff <= DEC_FIRST;
                    end else if (TEXT_STROBE) begin
                        glyph_code_ff  <= {lead_byte_ff, TEXT_BYTE};
                        glyph_full_ff  <= 1'b1;
                        glyph_valid_ff <= 1'b1;
                        dec_state_ff   <= DEC_FIRST;
                    end
                end
                default: begin
                    dec_state_ff <= DEC_FIRST;
                end
            endcase
        end
    end

    // fill engine; its busy flag is the readable fill-start bit
    window_fill_engine u_fill (
        .clock        (CLOCK),
        .rst_n        (RST_N),
        .start        (fill_start),
        .pattern      (fill_pattern_ff),
        .left_bound   (WINDOW_LEFT_BOUND),
        .top_bound    (WINDOW_TOP_BOUND),
        .right_bound  (WINDOW_RIGHT_BOUND),
        .bottom_bound (WINDOW_BOTTOM_BOUND),
        .mem_col      (DISPLAY_MEMORY_COL),
        .mem_row      (DISPLAY_MEMORY_ROW),
        .mem_data     (DISPLAY_MEMORY_DATA),
        .mem_we       (DISPLAY_MEMORY_WE),
        .busy         (fill_busy),
        .done         ()
    );

    // every port below leaves straight from a flip-flop
    assign DATA_OUT        = rd_data_ff;
    assign DATA_OE         = rd_oe_ff;
    assign GLYPH_CODE      = glyph_code_ff;
    assign GLYPH_VALID     = glyph_valid_ff;
    assign GLYPH_FULL_SIZE = glyph_full_ff;
    assign FONT_ISO_SET    = iso_set_ff;
    assign FONT_BLOCK      = block_ff;
    assign FONT_WIDTH_MUL  = width_mul_ff;
    assign FONT_HEIGHT_MUL = height_mul_ff;

endmodule // text_font_and_memory_fill_ctrl

`default_nettype wire

// [common/font_fill_regs.vh]
// register offsets, field positions, reset values and codes of the font and fill control block
`ifndef FONT_FILL_REGS_VH
`define FONT_FILL_REGS_VH

// register offsets on the parallel host port
`define OFS_FILL_PATTERN   8'he0
`define OFS_FONT_CONTROL   8'hf0
`define OFS_FONT_SCALE     8'hf1

// reset values
`define RST_FILL_PATTERN   8'h00
`define RST_FONT_CONTROL   8'h00
`define RST_FONT_SCALE     8'h00

// font_control field positions
`define FC_ISO_BIT         7
`define FC_FILL_BIT        3
`define FC_SINGLE_BIT      2
`define FC_BLOCK_HI        1
`define FC_BLOCK_LO        0

// font_scale field positions
`define FS_HSCALE_HI       7
`define FS_HSCALE_LO       6
`define FS_VSCALE_HI       5
`define FS_VSCALE_LO       4

// status byte returned on a command-phase read
`define STAT_BUSY_BIT      7

// first byte at or above this value opens a two-byte code
`define HALF_SIZE_LIMIT    8'h80

`endif

// [hdl/pin_sync.v]
// two flip-flop synchroniser for pins entering the clock domain
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    // clock and reset
    input  wire             clock,
    input  wire             rst_n,
    // asynchronous in, synchronous out
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] stable_ff;

    // first stage feeds only the second stage
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff   <= INIT;
            stable_ff <= INIT;
        end else begin
            meta_ff   <= async_in;
            stable_ff <= meta_ff;
        end
    end

    assign sync_out = stable_ff;

endmodule // pin_sync

`default_nettype wire

// [hdl/window_fill_engine.v]
// fills the active window of display memory with one pattern byte
`timescale 1ns/10ps
`default_nettype none

module window_fill_engine (
    // clock and reset
    input  wire       clock,
    input  wire       rst_n,
    // start request and window
    input  wire       start,
    input  wire [7:0] pattern,
    input  wire [7:0] left_bound,
    input  wire [7:0] top_bound,
    input  wire [7:0] right_bound,
    input  wire [7:0] bottom_bound,
    // display memory write side
    output wire [7:0] mem_col,
    output wire [7:0] mem_row,
    output wire [7:0] mem_data,
    output wire       mem_we,
    // progress
    output wire       busy,
    output wire       done
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_FILL = 2'b10;

    reg [1:0] state_ff;
    reg [7:0] col_ff;
    reg [7:0] row_ff;
    reg [7:0] data_ff;
    reg [7:0] left_ff;
    reg [7:0] right_ff;
    reg [7:0] bottom_ff;
    reg       we_ff;
    reg       done_ff;

    // bounds are frozen at start so a mid-fill window change cannot tear the fill
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= ST_IDLE;
            col_ff    <= 8'h00;
            row_ff    <= 8'h00;
            data_ff   <= 8'h00;
            left_ff   <= 8'h00;
            right_ff  <= 8'h00;
            bottom_ff <= 8'h00;
            we_ff     <= 1'b0;
            done_ff   <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    we_ff <= 1'b0;
                    if (start) begin
                        state_ff  <= ST_FILL;
                        col_ff    <= left_bound;
                        row_ff    <= top_bound;
                        left_ff   <= left_bound;
                        right_ff  <= right_bound;
                        bottom_ff <= bottom_bound;
                        data_ff   <= pattern;
                        we_ff     <= 1'b1;
                    end
                end
                ST_FILL: begin
                    // one location per cycle, columns first then rows
                    if (col_ff >= right_ff) begin
                        if (row_ff >= bottom_ff) begin
                            state_ff <= ST_IDLE;
                            we_ff    <= 1'b0;
                            done_ff  <= 1'b1;
                        end else begin
                            col_ff <= left_ff;
                            row_ff <= row_ff + 8'h01;
                        end
                    end else begin
                        col_ff <= col_ff + 8'h01;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    we_ff    <= 1'b0;
                end
            endcase
        end
    end

    assign mem_col  = col_ff;
    assign mem_row  = row_ff;
    assign mem_data = data_ff;
    assign mem_we   = we_ff;
    assign busy     = state_ff[1];
    assign done     = done_ff;

endmodule // window_fill_engine

`default_nettype wire

// [sim/text_font_and_memory_fill_ctrl_chk.sv]
// concurrent checks of text decode and window fill at the block's ports
`timescale 1ns/10ps
`default_nettype none
module text_font_and_memory_fill_ctrl_chk (
    // clock and reset
    input wire logic        CLOCK,
    input wire logic        RST_N,
    // text path
    input wire logic [7:0]  TEXT_BYTE,
    input wire logic        TEXT_STROBE,
    input wire logic [15:0] GLYPH_CODE,
    input wire logic        GLYPH_VALID,
    input wire logic        GLYPH_FULL_SIZE,
    // window and fill port
    input wire logic [7:0]  WINDOW_LEFT_BOUND,
    input wire logic [7:0]  WINDOW_TOP_BOUND,
    input wire logic [7:0]  WINDOW_RIGHT_BOUND,
    input wire logic [7:0]  WINDOW_BOTTOM_BOUND,
    input wire logic [7:0]  DISPLAY_MEMORY_COL,
    input wire logic [7:0]  DISPLAY_MEMORY_ROW,
    input wire logic [7:0]  DISPLAY_MEMORY_DATA,
    input wire logic        DISPLAY_MEMORY_WE
);
    // short aliases; bounds are held steady by the host during a fill
    wire logic [7:0] l = WINDOW_LEFT_BOUND;
    wire logic [7:0] t = WINDOW_TOP_BOUND;
    wire logic [7:0] r = WINDOW_RIGHT_BOUND;
    wire logic [7:0] b = WINDOW_BOTTOM_BOUND;
    wire logic [7:0] c = DISPLAY_MEMORY_COL;
    wire logic [7:0] w = DISPLAY_MEMORY_ROW;
    wire logic       we = DISPLAY_MEMORY_WE;

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    // last location of the window, then the write port goes quiet
    sequence s_last;
        we && c == r && w == b;
    endsequence
    sequence s_quiet;
        !we [*2];
    endsequence

    a_glyph_cause: assert property (GLYPH_VALID |-> $past(TEXT_STROBE))
        else $error("glyph without strobe");
    a_half_code: assert property (GLYPH_VALID && !GLYPH_FULL_SIZE |->
        GLYPH_CODE == {8'h00, $past(TEXT_BYTE)}) else $error("half code wrong");
    a_full_code: assert property (GLYPH_VALID && GLYPH_FULL_SIZE |->
        GLYPH_CODE[7:0] == $past(TEXT_BYTE) && GLYPH_CODE[15]) else $error("full code wrong");
    a_fill_inside: assert property (we |-> c >= l && c <= r && w >= t && w <= b)
        else $error("fill outside window");
    a_fill_first: assert property ($rose(we) |-> c == l && w == t)
        else $error("fill start location");
    a_raster_step: assert property (we && $past(we) |-> ($past(c) < r) ?
        (c == $past(c) + 8'h01 && w == $past(w)) : (c == l && w == $past(w) + 8'h01))
        else $error("fill not in raster order");
    a_fill_data: assert property (we && $past(we) |-> $stable(DISPLAY_MEMORY_DATA))
        else $error("fill data changed");
    a_fill_end: assert property (s_last |=> s_quiet)
        else $error("fill ran past window");
endmodule // text_font_and_memory_fill_ctrl_chk
`default_nettype wire

// [sim/host_bus_model.sv]
// host processor model on the 8080-style register port
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
    // clock and read return
    input  wire logic       CLOCK,
    input  wire logic [7:0] DATA_OUT,
    input  wire logic       DATA_OE,
    // strobes and data
    output var logic        CS,
    output var logic        RS,
    output var logic        WR_N,
    output var logic        RD_N,
    output var logic [7:0]  DATA_IN
);
    initial begin
        CS = 1'b0;
        RS = 1'b0;
        WR_N = 1'b1;
        RD_N = 1'b1;
        DATA_IN = 8'h5a;
    end

    // pins pass a synchroniser, so each phase is held four cycles
    task automatic strobe(input logic rs_v, input logic [7:0] d);
        @(negedge CLOCK);
        CS = 1'b1;
        RS = rs_v;
        DATA_IN = d;
        WR_N = 1'b0;
        repeat (4) @(negedge CLOCK);
        WR_N = 1'b1;
        repeat (4) @(negedge CLOCK);
        CS = 1'b0;
        DATA_IN = ~d; // released bus never keeps the old value
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        strobe(1'b1, a);
        strobe(1'b0, v);
    endtask

    // read of the addressed register, or of the status byte when rs_v is high; output enable is returned too
    task automatic rd(input logic rs_v, output logic [7:0] d, output logic oe);
        @(negedge CLOCK);
        CS = 1'b1;
        RS = rs_v;
        RD_N = 1'b0;
        repeat (6) @(negedge CLOCK);
        d = DATA_OUT;
        oe = DATA_OE;
        RD_N = 1'b1;
        repeat (5) @(negedge CLOCK);
        CS = 1'b0;
    endtask
endmodule // host_bus_model
`default_nettype wire

// [sim/test_text_font_and_memory_fill_ctrl.sv]
// self-checking bench for the font control and window fill block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_text_font_and_memory_fill_ctrl;
    logic        clock = 1'b0;
    logic        rst_n, cs, rs, wr_n, rd_n, oe, txt_mode, txt_stb, single_en, lead_pend;
    logic        g_valid, g_full, f_iso, m_we, last_full, rd_oe;
    logic [7:0]  din, dout, win_l, win_t, win_r, win_b, txt_byte, lead_b, pat, rd_d, v;
    logic [7:0]  m_col, m_row, m_dat;
    logic [15:0] g_code, last_code;
    logic [1:0]  f_blk;
    logic [2:0]  f_wm, f_hm;
    logic [31:0] seed = 32'hedac;
    int          error_cnt = 0, n_tests = 0, we_n = 0, glyph_n = 0, i;

    always #5 clock = ~clock;

    text_font_and_memory_fill_ctrl i_text_font_and_memory_fill_ctrl (
        .CLOCK(clock), .RST_N(rst_n), .CS(cs), .RS(rs), .WR_N(wr_n), .RD_N(rd_n),
        .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .WINDOW_LEFT_BOUND(win_l),
        .WINDOW_TOP_BOUND(win_t), .WINDOW_RIGHT_BOUND(win_r), .WINDOW_BOTTOM_BOUND(win_b),
        .TEXT_MODE(txt_mode), .TEXT_BYTE(txt_byte), .TEXT_STROBE(txt_stb),
        .GLYPH_CODE(g_code), .GLYPH_VALID(g_valid), .GLYPH_FULL_SIZE(g_full),
        .FONT_ISO_SET(f_iso), .FONT_BLOCK(f_blk), .FONT_WIDTH_MUL(f_wm),
        .FONT_HEIGHT_MUL(f_hm), .DISPLAY_MEMORY_COL(m_col), .DISPLAY_MEMORY_ROW(m_row),
        .DISPLAY_MEMORY_DATA(m_dat), .DISPLAY_MEMORY_WE(m_we));
    host_bus_model i_host_bus_model (.CLOCK(clock), .DATA_OUT(dout), .DATA_OE(oe),
        .CS(cs), .RS(rs), .WR_N(wr_n), .RD_N(rd_n), .DATA_IN(din));

    // counts fill writes and decoded glyphs as they leave the block
    always @(negedge clock) begin
        if (m_we === 1'b1) begin
            we_n++;
            `CHK("fill_data", pat, m_dat)
        end
        if (g_valid === 1'b1) begin
            glyph_n++;
            last_code = g_code;
            last_full = g_full;
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected decode {valid, full, code}; a lead byte waits for its partner
    function automatic logic [17:0] exp_glyph(input logic [7:0] b);
        if (!single_en && txt_mode && lead_pend) begin
            lead_pend = 1'b0;
            return {2'b11, lead_b, b};
        end
        if (!single_en && txt_mode && b >= 8'h80) begin
            lead_pend = 1'b1;
            lead_b = b;
            return 18'h0;
        end
        return {2'b10, 8'h00, b};
    endfunction

    task automatic send(input logic [7:0] b);
        int n0;
        logic [17:0] e;
        n0 = glyph_n;
        e = exp_glyph(b);
        @(negedge clock);
        txt_byte = b;
        txt_stb = 1'b1;
        @(negedge clock);
        txt_stb = 1'b0;
        txt_byte = ~b;
        repeat (3) @(negedge clock);
        `CHK("glyph_count", int'(e[17]), glyph_n - n0)
        if (e[17]) `CHK("glyph", e[16:0], {last_full, last_code})
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
        i_host_bus_model.strobe(1'b1, a);
        i_host_bus_model.rd(1'b0, rd_d, rd_oe);
        `CHK("reg_read", e, rd_d)
        `CHK("data_oe", 1'b1, rd_oe)
    endtask

    // fill a window; optionally restart while busy, which must be ignored
    task automatic fill(input logic [7:0] l, t, w, h, input logic again);
        int n;
        @(negedge clock);
        win_l = l;
        win_t = t;
        win_r = l + w - 8'h01;
        win_b = t + h - 8'h01;
        pat = 8'(rnd());
        i_host_bus_model.wr_reg(8'he0, pat);
        we_n = 0;
        i_host_bus_model.wr_reg(8'hf0, 8'h08);
        if (again) i_host_bus_model.strobe(1'b0, 8'h08);
        i_host_bus_model.rd(1'b1, rd_d, rd_oe);
        if (w * h > 23) `CHK("stat_busy", 1'b1, rd_d[7])
        i_host_bus_model.rd(1'b0, rd_d, rd_oe);
        if (w * h > 40) `CHK("fill_busy", 1'b1, rd_d[3])
        for (n = 0; n < 100 && rd_d[3] !== 1'b0; n++) i_host_bus_model.rd(1'b0, rd_d, rd_oe);
        `CHK("fill_done", 1'b0, rd_d[3])
        `CHK("fill_count", int'(w) * int'(h), we_n)
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // cut a hang well beyond the expected few thousand cycles
    initial begin
        #500000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        {rst_n, txt_mode, txt_stb, single_en, lead_pend} = 5'b0;
        {win_l, win_t, win_r, win_b, txt_byte, lead_b, pat} = 56'h0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        `CHK("width_mul", 3'd1, f_wm)
        reg_chk(8'he0, 8'h00);
        reg_chk(8'hf0, 8'h00);
        reg_chk(8'hf1, 8'h00);
        i_host_bus_model.wr_reg(8'h10, 8'hff);
        reg_chk(8'h10, 8'h00);
        for (i = 0; i < 4; i++) begin
            v = {~i[0], 3'b111, 2'b00, i[1:0]};
            we_n = 0;
            i_host_bus_model.wr_reg(8'hf0, v);
            reg_chk(8'hf0, v & 8'h87);
            `CHK("iso", v[7], f_iso)
            `CHK("block", i[1:0], f_blk)
            `CHK("no_fill", 0, we_n)
        end
        for (i = 0; i < 16; i++) begin
            v = {i[3:0], 4'hf};
            i_host_bus_model.wr_reg(8'hf1, v);
            reg_chk(8'hf1, v & 8'hf0);
            `CHK("width_mul", {1'b0, i[3:2]} + 3'd1, f_wm)
            `CHK("height_mul", {1'b0, i[1:0]} + 3'd1, f_hm)
        end
        for (i = 0; i < 4; i++) begin
            v = 8'(rnd());
            i_host_bus_model.wr_reg(8'he0, v);
            reg_chk(8'he0, v);
        end
        fill(8'hfc, 8'hfd, 8'd4, 8'd3, 1'b0);
        fill(8'd2, 8'd1, 8'd10, 8'd8, 1'b1);
        repeat (3) fill(8'(rnd() % 32), 8'(rnd() % 32), 8'(4 + rnd() % 4), 8'(4 + rnd() % 4), 1'b0);
        for (i = 0; i < 4; i++) begin
            single_en = i[1];
            i_host_bus_model.wr_reg(8'hf0, {5'b0, i[1], 2'b00});
            txt_mode = i[0];
            send(8'h7f);
            send(8'h80);
            send(8'hff);
            send(8'h00);
            repeat (12) send(8'(rnd()));
            send(8'h41);
        end
        wrap_up();
    end
endmodule // test_text_font_and_memory_fill_ctrl
bind text_font_and_memory_fill_ctrl text_font_and_memory_fill_ctrl_chk i_chk (
    .CLOCK(CLOCK), .RST_N(RST_N), .TEXT_BYTE(TEXT_BYTE), .TEXT_STROBE(TEXT_STROBE),
    .GLYPH_CODE(GLYPH_CODE), .GLYPH_VALID(GLYPH_VALID), .GLYPH_FULL_SIZE(GLYPH_FULL_SIZE),
    .WINDOW_LEFT_BOUND(WINDOW_LEFT_BOUND), .WINDOW_TOP_BOUND(WINDOW_TOP_BOUND),
    .WINDOW_RIGHT_BOUND(WINDOW_RIGHT_BOUND), .WINDOW_BOTTOM_BOUND(WINDOW_BOTTOM_BOUND),
    .DISPLAY_MEMORY_COL(DISPLAY_MEMORY_COL), .DISPLAY_MEMORY_ROW(DISPLAY_MEMORY_ROW),
    .DISPLAY_MEMORY_DATA(DISPLAY_MEMORY_DATA), .DISPLAY_MEMORY_WE(DISPLAY_MEMORY_WE));
`default_nettype wire
